// ===== hw/sslpc_defs.svh
// constants of the synthesizer serial load and phase control block
`ifndef SSLPC_DEFS_SVH
`define SSLPC_DEFS_SVH

// ----------------------------------------------------------------------
// serial word
// ----------------------------------------------------------------------
// word length is not fixed by the part; plain default
`define SSLPC_WORD_W 18
// position of the destination select bit, the last bit shifted in
`define SSLPC_CTL_BIT 0
// control bit value per destination latch
`define SSLPC_CTL_REF 1'b0
`define SSLPC_CTL_RF 1'b1

// ----------------------------------------------------------------------
// latch fields and reset values
// ----------------------------------------------------------------------
// bit of the reference latch that steers the comparator monitor
`define SSLPC_MON_SEL_BIT 1
`define SSLPC_LATCH_RST 18'h00000

// ----------------------------------------------------------------------
// clocking
// ----------------------------------------------------------------------
`define SSLPC_CLK_PERIOD_PS 4000
// flops in each pin synchroniser
`define SSLPC_SYNC_STAGES 2

`endif

// ===== hw/sslpc_latch_bank.sv
// two-word destination latch bank with registered read data
`timescale 1ns/1ps
`include "sslpc_defs.svh"

module sslpc_latch_bank
  import sslpc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // write port
  input wire logic wr_en_i,
  input wire logic wr_sel_i,
  input wire logic [`SSLPC_WORD_W-1:0] wr_data_i,
  // read data
  output logic [`SSLPC_WORD_W-1:0] ref_word_o,
  output logic [`SSLPC_WORD_W-1:0] rf_word_o
);

  logic [`SSLPC_WORD_W-1:0] mem_r [2];
  wire wr_ref = wr_en_i && (wr_sel_i == `SSLPC_CTL_REF);
  wire wr_rf = wr_en_i && (wr_sel_i == `SSLPC_CTL_RF);

  // storage: only the selected word changes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_r[0] <= `SSLPC_LATCH_RST;
      mem_r[1] <= `SSLPC_LATCH_RST;
    end else begin
      if (wr_ref) mem_r[0] <= wr_data_i;
      if (wr_rf) mem_r[1] <= wr_data_i;
    end
  end

  // read data from flops, follows storage by one cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_word_o <= `SSLPC_LATCH_RST;
      rf_word_o <= `SSLPC_LATCH_RST;
    end else begin
      ref_word_o <= mem_r[0];
      rf_word_o <= mem_r[1];
    end
  end

endmodule

// ===== hw/sslpc_pkg.sv
// types of the synthesizer serial load and phase control block
package sslpc_pkg;

  // --------------------------------------------------------------------
  // phase detector state
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSLPC_PFD_IDLE,
    SSLPC_PFD_UP,
    SSLPC_PFD_DN
  } sslpc_pfd_e;

  // --------------------------------------------------------------------
  // charge pump drive pair
  // --------------------------------------------------------------------
  typedef struct packed {
    logic up;
    logic dn;
  } sslpc_pump_s;

endpackage

// ===== hw/sslpc_top.sv
// serial load port, latch transfer and phase control of the synthesizer
`timescale 1ns/1ps
`include "sslpc_defs.svh"

module sslpc_top
  import sslpc_pkg::*;
(
  // core clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial load port from the host
  input wire logic serial_clk_i,
  input wire logic serial_data_i,
  input wire logic load_strobe_i,
  // phase sense pin, pulled up outside
  input wire logic phase_sense_select_i,
  // divider pulses from on-chip counters, core clock domain
  input wire logic ref_div_pulse_i,
  input wire logic rf_divider_pulse_i,
  // charge pump drive
  output sslpc_pump_s pump_o,
  // switch output: drive and enable
  output sslpc_pump_s pump_switch_output_o,
  output logic pump_switch_output_oe_o,
  // status and monitor
  output logic lock_indicator_o,
  output logic cmp_monitor_o,
  // latched words for the counters
  output logic [`SSLPC_WORD_W-1:0] ref_word_o,
  output logic [`SSLPC_WORD_W-1:0] rf_word_o
);

  // ----------------------------------------------------------------------
  // link side: shift register on the serial clock
  // ----------------------------------------------------------------------
  logic [`SSLPC_WORD_W-1:0] shift_r;

  // msb enters first and ends at the top; the control bit ends at bit 0
  always_ff @(posedge serial_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_r <= '0;
    end else begin
      shift_r <= {shift_r[`SSLPC_WORD_W-2:0], serial_data_i};
    end
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic le_s1_r, le_s2_r, le_s3_r;
  logic fc_s1_r, fc_s2_r;

  // first stages feed only the second stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      le_s1_r <= 1'b0;
      le_s2_r <= 1'b0;
      le_s3_r <= 1'b0;
      fc_s1_r <= 1'b1;
      fc_s2_r <= 1'b1;
    end else begin
      le_s1_r <= load_strobe_i;
      le_s2_r <= le_s1_r;
      le_s3_r <= le_s2_r;
      fc_s1_r <= phase_sense_select_i;
      fc_s2_r <= fc_s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // word transfer
  // ----------------------------------------------------------------------
  // the shift word crosses as a quiet bus: the serial clock is held low
  // around the strobe edge, so it is stable when the synced edge arrives
  wire le_rise = le_s2_r && !le_s3_r;
  wire xfer_sel = shift_r[`SSLPC_CTL_BIT];

  sslpc_latch_bank u_latch_bank (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(le_rise),
    .wr_sel_i(xfer_sel),
    .wr_data_i(shift_r),
    .ref_word_o(ref_word_o),
    .rf_word_o(rf_word_o)
  );

  // ----------------------------------------------------------------------
  // phase detector
  // ----------------------------------------------------------------------
  sslpc_pfd_e pfd_r, pfd_nxt;

  // coincident pulses cancel so no drive is emitted for zero error
  always_comb begin
    pfd_nxt = pfd_r;
    case (pfd_r)
      SSLPC_PFD_IDLE: begin
        if (ref_div_pulse_i && !rf_divider_pulse_i) pfd_nxt = SSLPC_PFD_UP;
        else if (rf_divider_pulse_i && !ref_div_pulse_i) pfd_nxt = SSLPC_PFD_DN;
      end
      SSLPC_PFD_UP: begin
        if (rf_divider_pulse_i) pfd_nxt = SSLPC_PFD_IDLE;
      end
      SSLPC_PFD_DN: begin
        if (ref_div_pulse_i) pfd_nxt = SSLPC_PFD_IDLE;
      end
      default: pfd_nxt = SSLPC_PFD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pfd_r <= SSLPC_PFD_IDLE;
    else pfd_r <= pfd_nxt;
  end

  // ----------------------------------------------------------------------
  // polarity, switch and status decode
  // ----------------------------------------------------------------------
  wire pol_normal = fc_s2_r;
  wire pfd_up = (pfd_r == SSLPC_PFD_UP);
  wire pfd_dn = (pfd_r == SSLPC_PFD_DN);
  sslpc_pump_s pump_nxt;
  assign pump_nxt.up = pol_normal ? pfd_up : pfd_dn;
  assign pump_nxt.dn = pol_normal ? pfd_dn : pfd_up;
  wire pump_active = pfd_up || pfd_dn;
  wire mon_sel = ref_word_o[`SSLPC_MON_SEL_BIT];
  wire mon_nxt = mon_sel ? rf_divider_pulse_i : ref_div_pulse_i;

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  // switch copy is gated by the synced strobe, so it opens a few
  // cycles after the pin; the analog path is not modelled here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pump_o <= '0;
      pump_switch_output_o <= '0;
      pump_switch_output_oe_o <= 1'b0;
      lock_indicator_o <= 1'b0;
      cmp_monitor_o <= 1'b0;
    end else begin
      pump_o <= pump_nxt;
      pump_switch_output_o <= le_s2_r ? pump_nxt : '0;
      pump_switch_output_oe_o <= le_s2_r;
      lock_indicator_o <= !pump_active;
      cmp_monitor_o <= mon_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // assertions, link domain
  // ----------------------------------------------------------------------
  property shift_in_p;
    @(posedge serial_clk_i) disable iff (!rst_n_i)
      1'b1 |=> (shift_r[0] == $past(serial_data_i));
  endproperty
  shift_sample_a: assert property (shift_in_p)
    else $error("serial bit not sampled into shift register");

  shift_order_a: assert property (
    @(posedge serial_clk_i) disable iff (!rst_n_i)
      1'b1 |=> (shift_r[`SSLPC_WORD_W-1:1] == $past(shift_r[`SSLPC_WORD_W-2:0])))
    else $error("shift register did not move toward msb");

  // ----------------------------------------------------------------------
  // assertions, core domain
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence strobe_edge_s;
    !le_s1_r ##1 le_s1_r ##1 1'b1;
  endsequence

  load_xfer_a: assert property (
    le_rise && !xfer_sel |-> ##2 (ref_word_o == $past(shift_r, 2)))
    else $error("reference latch missed the shifted word");

  load_xfer_rf_a: assert property (
    le_rise && xfer_sel |-> ##2 (rf_word_o == $past(shift_r, 2)))
    else $error("rf latch missed the shifted word");

  latch_hold_a: assert property (
    !le_rise |-> ##2 ($stable(ref_word_o) && $stable(rf_word_o)))
    else $error("latch changed without a strobe rise");

  strobe_rise_a: assert property (
    strobe_edge_s |-> le_rise)
    else $error("strobe rise not detected");

  switch_close_a: assert property (
    $rose(le_s1_r) |-> ##2 pump_switch_output_oe_o)
    else $error("switch not closed after strobe rise");

  switch_open_a: assert property (
    !pump_switch_output_oe_o |-> (pump_switch_output_o == '0))
    else $error("switch drives while open");

  pol_normal_a: assert property (
    (pfd_up && pol_normal) |=> (pump_o.up && !pump_o.dn))
    else $error("normal polarity not applied");

  pol_invert_a: assert property (
    (pfd_up && !pol_normal) |=> (pump_o.dn && !pump_o.up))
    else $error("inverted polarity not applied");

  lock_high_a: assert property (
    (!pfd_up && !pfd_dn) [*2] |=> lock_indicator_o[*1])
    else $error("lock indicator low while idle");

  lock_pulse_a: assert property (
    (pump_o.up || pump_o.dn) |-> !lock_indicator_o)
    else $error("lock indicator high during pump drive");

  monitor_sel_a: assert property (
    1'b1 |=> (cmp_monitor_o == $past(mon_sel ? rf_divider_pulse_i : ref_div_pulse_i)))
    else $error("monitor output does not follow selected input");

  // ----------------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------------
  cov_load_ref_c: cover property (le_rise && !xfer_sel);
  cov_load_rf_c: cover property (le_rise && xfer_sel);
  cov_inverted_c: cover property (pfd_up && !pol_normal);
  cov_lock_pulse_c: cover property (lock_indicator_o ##1 !lock_indicator_o ##1 lock_indicator_o);

endmodule

// ===== testbench/sslpc_host_model.sv
// host model driving the three-wire serial load port of the synthesizer
`timescale 1ns/1ps

module sslpc_host_model (
  // serial load port toward the device
  output logic serial_clk_o,
  output logic serial_data_o,
  output logic load_strobe_o
);
  // ----------------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------------
  initial begin
    serial_clk_o = 1'b0;
    serial_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end

  // 32 ns serial period; the clock stands low outside frames
  task automatic shift_bits(input logic [35:0] bits, input int n);
    #1.3;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_o = bits[i];
      #16 serial_clk_o = 1'b1;
      #16 serial_clk_o = 1'b0;
    end
    // hold time over: the line must not keep showing the last bit
    serial_data_o = ~serial_data_o;
  endtask

  // strobe moves only with the serial clock low, quiet on both sides
  task automatic set_strobe(input logic level);
    #33.3 load_strobe_o = level;
    #40;
  endtask
endmodule

// ===== testbench/tb_sslpc_top.sv
// self-checking bench of the serial load and phase control block
`timescale 1ns/1ps
`include "sslpc_defs.svh"

module tb_sslpc_top;
  import sslpc_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sclk, sdata, strobe;
  logic sense;
  logic ref_p;
  logic rf_p;
  sslpc_pump_s pump, sw;
  logic sw_oe, lock, mon;
  logic [`SSLPC_WORD_W-1:0] ref_w, rf_w;
  int err_count = 0;
  int n_tests = 0;

  always #2 clk_i = ~clk_i;

  sslpc_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_clk_i(sclk),
    .serial_data_i(sdata), .load_strobe_i(strobe), .phase_sense_select_i(sense),
    .ref_div_pulse_i(ref_p), .rf_divider_pulse_i(rf_p), .pump_o(pump),
    .pump_switch_output_o(sw), .pump_switch_output_oe_o(sw_oe),
    .lock_indicator_o(lock), .cmp_monitor_o(mon), .ref_word_o(ref_w), .rf_word_o(rf_w));

  sslpc_host_model host (.serial_clk_o(sclk), .serial_data_o(sdata), .load_strobe_o(strobe));

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // settle one time unit after the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(input logic r, input logic f);
    @(posedge clk_i);
    ref_p <= r;
    rf_p <= f;
    @(posedge clk_i);
    ref_p <= 1'b0;
    rf_p <= 1'b0;
  endtask

  // counts monitor highs after one divider pulse; bounded window
  task automatic mon_count(input logic r, input logic f, output int cnt);
    cnt = 0;
    @(posedge clk_i);
    ref_p <= r;
    rf_p <= f;
    repeat (6) begin
      @(posedge clk_i);
      ref_p <= 1'b0;
      rf_p <= 1'b0;
      #1;
      if (mon === 1'b1) cnt++;
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_load_ref();
    host.shift_bits(36'h2a5a8, 18);
    host.set_strobe(1'b1);
    check(ref_w, 36'h2a5a8, "ref latch");
    check(rf_w, 36'h0, "rf latch untouched");
    host.set_strobe(1'b0);
  endtask

  task automatic t_quiet_shift();
    host.shift_bits(36'h3ffff, 18);
    tick(8);
    check(ref_w, 36'h2a5a8, "ref held while strobe low");
    check(rf_w, 36'h0, "rf held while strobe low");
  endtask

  // four stale bits ahead of the word get pushed out
  task automatic t_load_rf();
    host.shift_bits({14'h0, 4'hf, 18'h1357b}, 22);
    host.set_strobe(1'b1);
    check(rf_w, 36'h1357b, "rf latch last bits");
    check(ref_w, 36'h2a5a8, "ref unchanged");
    host.set_strobe(1'b0);
  endtask

  task automatic t_switch();
    pulse(1'b1, 1'b0);
    host.set_strobe(1'b1);
    check(sw_oe, 1'b1, "switch closed");
    check({sw.up, sw.dn}, 2'b10, "switch carries drive");
    host.set_strobe(1'b0);
    tick(4);
    check(sw_oe, 1'b0, "switch open");
    check({sw.up, sw.dn}, 2'b00, "switch drive idle");
    pulse(1'b0, 1'b1);
    tick(3);
  endtask

  task automatic t_phase();
    pulse(1'b1, 1'b0);
    tick(3);
    check({pump.up, pump.dn}, 2'b10, "normal up");
    check(lock, 1'b0, "lock low during drive");
    pulse(1'b0, 1'b1);
    tick(3);
    check({pump.up, pump.dn}, 2'b00, "idle");
    check(lock, 1'b1, "lock high idle");
    @(posedge clk_i);
    sense <= 1'b0;
    tick(5);
    pulse(1'b1, 1'b0);
    tick(3);
    check({pump.up, pump.dn}, 2'b01, "inverted");
    pulse(1'b0, 1'b1);
    @(posedge clk_i);
    sense <= 1'b1;
    tick(5);
  endtask

  // ref latch bit 1 is 0, so the reference pulse is monitored
  task automatic t_monitor();
    int cnt;
    mon_count(1'b1, 1'b0, cnt);
    check(36'(cnt), 36'h1, "ref pulse on monitor");
    mon_count(1'b0, 1'b1, cnt);
    check(36'(cnt), 36'h0, "rf pulse not monitored");
  endtask

  // ref latch bit 1 set: the rf pulse is monitored instead
  task automatic t_monitor_rf();
    int cnt;
    host.shift_bits(36'h2a5aa, 18);
    host.set_strobe(1'b1);
    check(ref_w, 36'h2a5aa, "ref latch reloaded");
    host.set_strobe(1'b0);
    mon_count(1'b0, 1'b1, cnt);
    check(36'(cnt), 36'h1, "rf pulse on monitor");
    mon_count(1'b1, 1'b0, cnt);
    check(36'(cnt), 36'h0, "ref pulse not monitored");
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    sense = 1'b1;
    ref_p = 1'b0;
    rf_p = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(2);
    check(lock, 1'b1, "lock after reset");
    t_load_ref();
    t_quiet_shift();
    t_monitor();
    t_load_rf();
    t_switch();
    t_phase();
    t_monitor_rf();
    end_sim();
  end
endmodule
